// file: dirflag_pkg.sv
// Function
// RQ1: flag at 0 keeps the data line output released (high impedance).
// RQ2: flag at 1 drives the data line from the output bit latch after ninth clock.
// RQ3: stop condition detected or reset clears the flag.
// RQ4: software writing 1 to the exit-communication bit clears the flag.
// RQ5: interface enable falling from 1 to 0 clears the flag.
// RQ6: software writing 1 to the wait-release bit clears the flag.
// RQ7: arbitration-lost flag rising from 0 to 1 clears the flag.
// RQ8: master sending 1 as first byte LSB (read) clears the flag.
// RQ9: slave detecting a start condition clears the flag.
// RQ10: master generating a start condition sets the flag.
// RQ11: master sending 0 as first byte LSB (write) sets the flag.
// RQ12: slave receiving 1 as first byte LSB sets the flag.
// RQ13: wait release at ninth clock with flag 1 clears it and releases the line.
package dirflag_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   // control field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_EXIT_BIT   = 1;
   localparam int CTRL_WREL_BIT   = 2;
   // status field positions
   localparam int STAT_FLAG_BIT   = 0;
   localparam int STAT_DRIVE_BIT  = 1;
   localparam int STAT_NINTH_BIT  = 2;
   localparam int STAT_LINE_BIT   = 3;
   // reset values
   localparam logic        ENABLE_RST = 1'b0;
   localparam logic        FLAG_RST   = 1'b0;
   localparam logic        LINE_RST   = 1'b1;
   localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
endpackage

// file: dirflag.sv
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
module dirflag
   import dirflag_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        master_role,
   input  wire logic        start_generated,
   input  wire logic        start_detected,
   input  wire logic        stop_detected,
   input  wire logic        arbitration_lost_flag,
   input  wire logic        first_lsb_strobe,
   input  wire logic        first_lsb_value,
   input  wire logic        ninth_clock_rise,
   input  wire logic        out_bit_latch,
   input  wire logic        serial_data_line_in,
   output logic             serial_data_line_out,
   output logic             serial_data_line_oe,
   output logic             direction_flag
);

   // address decode shared by write, read and error paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic        enable_r, enable_nxt;
   logic        flag_r, flag_nxt;
   logic        ald_prev_r, ald_prev_nxt;
   logic        ninth_r, ninth_nxt;
   logic        sda_out_r, sda_out_nxt;
   logic        sda_oe_r, sda_oe_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        access, ctrl_wr, mapped;
   logic        exit_wr, wrel_wr, en_fall, ald_rise;
   logic        clr_ev, set_ev;
   logic        line_s1_r, line_s2_r, line_s3_r;
   logic        line_lvl_r, line_lvl_nxt;

   // three stage pin synchroniser; only the first stage sees the raw pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_s1_r <= LINE_RST;
         line_s2_r <= LINE_RST;
         line_s3_r <= LINE_RST;
      end else begin
         line_s1_r <= serial_data_line_in;
         line_s2_r <= line_s1_r;
         line_s3_r <= line_s2_r;
      end
   end

   // line level changes only once second and third stages agree
   always_comb begin
      line_lvl_nxt = line_lvl_r;
      if (line_s2_r == line_s3_r) begin
         line_lvl_nxt = line_s3_r;
      end
   end

   // filtered line level register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_lvl_r <= LINE_RST;
      end else begin
         line_lvl_r <= line_lvl_nxt;
      end
   end

   // bus strobes, zero wait state
   assign access  = psel & penable;
   assign mapped  = hit(paddr, CTRL_OFF) | hit(paddr, STATUS_OFF);
   assign ctrl_wr = access & pwrite & hit(paddr, CTRL_OFF);
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata  = prdata_r;

   // event decode for the direction flag
   assign exit_wr  = ctrl_wr & pwdata[CTRL_EXIT_BIT];
   assign wrel_wr  = ctrl_wr & pwdata[CTRL_WREL_BIT];
   assign en_fall  = enable_r & ~enable_nxt;
   assign ald_rise = arbitration_lost_flag & ~ald_prev_r;
   assign clr_ev   = stop_detected                                  // see RQ3
                   | exit_wr                                        // see RQ4
                   | en_fall                                        // see RQ5
                   | wrel_wr                                        // see RQ6 see RQ13
                   | ald_rise                                       // see RQ7
                   | (master_role & first_lsb_strobe & first_lsb_value) // see RQ8
                   | (~master_role & start_detected);               // see RQ9
   assign set_ev   = enable_nxt & ((master_role & start_generated)  // see RQ10
                   | (master_role & first_lsb_strobe & ~first_lsb_value) // see RQ11
                   | (~master_role & first_lsb_strobe & first_lsb_value)); // see RQ12

   // next state of control, flag and pin driver
   always_comb begin
      enable_nxt   = enable_r;
      ald_prev_nxt = arbitration_lost_flag;
      ninth_nxt    = ninth_r;
      prdata_nxt   = prdata_r;
      if (ctrl_wr) begin
         enable_nxt = pwdata[CTRL_ENABLE_BIT];
      end
      // hardware set wins over any clear in the same cycle except an enable fall, which blocks the set
      flag_nxt = flag_r;
      if (clr_ev) begin
         flag_nxt = 1'b0;
      end
      if (set_ev) begin
         flag_nxt = 1'b1;
      end
      // drive window opens at the first byte's ninth clock
      if (start_detected | start_generated | stop_detected | en_fall) begin
         ninth_nxt = 1'b0;
      end else if (ninth_clock_rise) begin
         ninth_nxt = 1'b1;
      end
      sda_oe_nxt  = flag_nxt & ninth_nxt;                            // see RQ1 see RQ2
      sda_out_nxt = sda_oe_nxt & out_bit_latch;                      // see RQ2
      // read data captured in the setup cycle
      if (psel & ~penable & ~pwrite) begin
         prdata_nxt = 32'h0000_0000;
         if (hit(paddr, CTRL_OFF)) begin
            prdata_nxt[CTRL_ENABLE_BIT] = enable_r;
         end
         if (hit(paddr, STATUS_OFF)) begin
            prdata_nxt[STAT_FLAG_BIT]  = flag_r;
            prdata_nxt[STAT_DRIVE_BIT] = sda_oe_r;
            prdata_nxt[STAT_NINTH_BIT] = ninth_r;
            prdata_nxt[STAT_LINE_BIT]  = line_lvl_r;
         end
      end
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_r   <= ENABLE_RST;
         flag_r     <= FLAG_RST;                                     // see RQ3
         ald_prev_r <= 1'b0;
         ninth_r    <= 1'b0;
         sda_out_r  <= 1'b0;
         sda_oe_r   <= 1'b0;
         prdata_r   <= PRDATA_RST;
      end else begin
         enable_r   <= enable_nxt;
         flag_r     <= flag_nxt;
         ald_prev_r <= ald_prev_nxt;
         ninth_r    <= ninth_nxt;
         sda_out_r  <= sda_out_nxt;
         sda_oe_r   <= sda_oe_nxt;
         prdata_r   <= prdata_nxt;
      end
   end

   assign serial_data_line_out = sda_out_r;
   assign serial_data_line_oe  = sda_oe_r;
   assign direction_flag       = flag_r;

   // checks
   AST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn) // see RQ1
      !direction_flag |-> !serial_data_line_oe)
      else $error("data line driven while flag is 0");
   AST_DRIVE: assert property (@(posedge pclk) disable iff (!presetn) // see RQ2
      serial_data_line_oe |-> (serial_data_line_out == $past(out_bit_latch)))
      else $error("data line not driven from output latch");
   AST_STOP: assert property (@(posedge pclk) disable iff (!presetn) // see RQ3
      stop_detected && !set_ev |=> !direction_flag)
      else $error("stop did not clear flag");
   AST_EXIT: assert property (@(posedge pclk) disable iff (!presetn) // see RQ4
      exit_wr && !set_ev |=> !direction_flag)
      else $error("exit write did not clear flag");
   AST_ENFALL: assert property (@(posedge pclk) disable iff (!presetn) // see RQ5
      $fell(enable_r) |-> !direction_flag)
      else $error("disable did not clear flag");
   AST_WREL: assert property (@(posedge pclk) disable iff (!presetn) // see RQ6
      wrel_wr && !set_ev |=> !direction_flag)
      else $error("wait release did not clear flag");
   AST_ALD: assert property (@(posedge pclk) disable iff (!presetn) // see RQ7
      $rose(arbitration_lost_flag) && !set_ev |=> !direction_flag)
      else $error("arbitration loss did not clear flag");
   AST_MREAD: assert property (@(posedge pclk) disable iff (!presetn) // see RQ8
      master_role && first_lsb_strobe && first_lsb_value && !start_generated |=> !direction_flag)
      else $error("master read did not clear flag");
   AST_SSTART: assert property (@(posedge pclk) disable iff (!presetn) // see RQ9
      !master_role && start_detected && !first_lsb_strobe |=> !direction_flag)
      else $error("slave start did not clear flag");
   AST_MSTART: assert property (@(posedge pclk) disable iff (!presetn) // see RQ10
      master_role && start_generated && enable_nxt |=> direction_flag)
      else $error("start generation did not set flag");
   AST_MWRITE: assert property (@(posedge pclk) disable iff (!presetn) // see RQ11
      master_role && first_lsb_strobe && !first_lsb_value && enable_nxt |=> direction_flag)
      else $error("master write did not set flag");
   AST_SREAD: assert property (@(posedge pclk) disable iff (!presetn) // see RQ12
      !master_role && first_lsb_strobe && first_lsb_value && enable_nxt |=> direction_flag)
      else $error("slave read request did not set flag");
   AST_WREL_RELEASE: assert property (@(posedge pclk) disable iff (!presetn) // see RQ13
      direction_flag && wrel_wr && !set_ev |=> !serial_data_line_oe)
      else $error("wait release did not release the line");
   COV_MASTER_TX: cover property (@(posedge pclk) disable iff (!presetn)
      master_role && start_generated ##[1:100] serial_data_line_oe);
   COV_SLAVE_TX: cover property (@(posedge pclk) disable iff (!presetn)
      !master_role && first_lsb_strobe && first_lsb_value ##[1:100] serial_data_line_oe);
   COV_WREL: cover property (@(posedge pclk) disable iff (!presetn)
      direction_flag && wrel_wr);

   // released output never carries a stale high
   AST_OUT_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // see RQ1
      !serial_data_line_oe |-> !serial_data_line_out)
      else $error("data output high while released");

   // drive only inside the window opened at the ninth clock
   AST_OE_WINDOW: assert property (@(posedge pclk) disable iff (!presetn) // see RQ2
      serial_data_line_oe |-> ninth_r)
      else $error("data line driven before ninth clock");

   // a stop closes the drive window at once
   AST_STOP_RELEASE: assert property (@(posedge pclk) disable iff (!presetn) // see RQ3
      stop_detected |=> !serial_data_line_oe)
      else $error("data line still driven after stop");

   // no set may land while the interface stays disabled
   AST_DISABLED: assert property (@(posedge pclk) disable iff (!presetn) // see RQ5
      !enable_r && !ctrl_wr && !direction_flag |=> !direction_flag)
      else $error("flag set while interface disabled");

   // set wins over a clear in the same cycle
   AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn) // see RQ10
      set_ev |=> direction_flag)
      else $error("set event lost against clear");

   // flag holds when nothing sets or clears it
   AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !clr_ev && !set_ev |=> direction_flag == $past(direction_flag))
      else $error("flag changed without an event");

   // enable bit follows the control write
   AST_ENABLE_WR: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_wr |=> enable_r == $past(pwdata[CTRL_ENABLE_BIT]))
      else $error("enable bit did not follow write");

   // unmapped access answers with an error
   AST_SLVERR: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && (paddr != CTRL_OFF) && (paddr != STATUS_OFF) |-> pslverr)
      else $error("unmapped access without error");

   // filtered line takes the agreed synchroniser value
   AST_LINE_FILTER: assert property (@(posedge pclk) disable iff (!presetn)
      line_s2_r == line_s3_r |=> line_lvl_r == $past(line_s3_r))
      else $error("line filter did not follow agreed level");

   // exit and disable scenarios
   COV_EXIT: cover property (@(posedge pclk) disable iff (!presetn)
      direction_flag && exit_wr);
   COV_DISABLE: cover property (@(posedge pclk) disable iff (!presetn)
      direction_flag && en_fall);
endmodule

// file: bus_partner.sv
`timescale 1ns/100ps
module bus_partner (
   output logic start_detected,
   output logic stop_detected,
   output logic arbitration_lost_flag,
   output logic first_lsb_strobe,
   output logic first_lsb_value,
   output logic ninth_clock_rise,
   output logic out_bit_latch
);
   // bus events from other masters and slaves, changed just after a clock edge
   task automatic drive(input logic [6:0] v);
      start_detected        <= v[0];
      stop_detected         <= v[1];
      arbitration_lost_flag <= v[2];
      first_lsb_strobe      <= v[3];
      first_lsb_value       <= v[4];
      ninth_clock_rise      <= v[5];
      out_bit_latch         <= v[6];
   endtask
   initial drive(7'h00);
endmodule

// file: tb_i2c_transfer_direction_flag.sv
`timescale 1ns/100ps
module tb_i2c_transfer_direction_flag;
   import dirflag_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, master_role, start_generated;
   logic        start_detected, stop_detected, arbitration_lost_flag, first_lsb_strobe, first_lsb_value;
   logic        ninth_clock_rise, out_bit_latch, so, oe, flag, ef, al_q, e;
   logic [7:0]  paddr;
   logic [6:0]  cur;
   logic [31:0] pwdata, prdata, q, rnd;
   int          num_errors, total_checks;
   wire         serial_data_line_in = oe ? so : 1'b1; // pulled up when released
   bus_partner bus (.start_detected, .stop_detected, .arbitration_lost_flag, .first_lsb_strobe,
      .first_lsb_value, .ninth_clock_rise, .out_bit_latch);
   dirflag DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .master_role, .start_generated, .start_detected, .stop_detected, .arbitration_lost_flag,
      .first_lsb_strobe, .first_lsb_value, .ninth_clock_rise, .out_bit_latch, .serial_data_line_in,
      .serial_data_line_out(so), .serial_data_line_oe(oe), .direction_flag(flag));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // expected flag after one edge; set wins over clear
   function automatic logic nxt(input logic f, m, g, a, input logic [6:0] v);
      if ((m & g) | (v[3] & (m ? ~v[4] : v[4]))) return 1'b1;
      if (v[1] | a | (m & v[3] & v[4]) | (~m & v[0])) return 1'b0;
      return f;
   endfunction
   task automatic check(input string n, input logic [31:0] s, x);
      total_checks++;
      if (s !== x) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", n, x, s);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one apb transfer, entered and left just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // one-cycle event, latch and arbitration level kept afterwards
   task automatic pulse(input logic g, input logic [6:0] v);
      start_generated <= g;
      bus.drive(v);
      @(posedge pclk);
      start_generated <= 1'b0;
      bus.drive(v & 7'h44);
      @(posedge pclk);
   endtask
   // watchdog
   initial begin
      repeat (3000) @(posedge pclk);
      num_errors++;
      results();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, start_generated} = '0;
      master_role = 1'b1;
      rnd = 32'hf325ba2e;
      {ef, al_q, cur} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      check("flag", flag, 1'b0);
      @(posedge pclk);
      apb(1'b1, CTRL_OFF, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      check("pslverr", e, 1'b1);
      // random bus events in both roles against the reference
      for (int i = 0; i < 400; i++) begin
         @(posedge pclk);
         ef = nxt(ef, master_role, start_generated, cur[2] & ~al_q, cur);
         al_q = cur[2];
         rnd = lfsr(rnd);
         cur = rnd[6:0] & rnd[13:7];
         master_role <= rnd[20];
         start_generated <= rnd[21] & rnd[22];
         bus.drive(cur);
         @(negedge pclk);
         check("flag", flag, ef);
         if (flag === 1'b0) check("oe", oe, 1'b0);
      end
      @(posedge pclk);
      master_role <= 1'b1;
      start_generated <= 1'b0;
      bus.drive(7'h00);
      @(posedge pclk);
      pulse(1'b1, 7'h40);
      check("flag", flag, 1'b1);
      pulse(1'b0, 7'h60);
      @(negedge pclk);
      check("oe", oe, 1'b1);
      check("out", so, 1'b1);
      @(posedge pclk);
      apb(1'b0, STATUS_OFF, 32'h0);
      check("status", q[STAT_FLAG_BIT], 1'b1);
      check("line", q[STAT_LINE_BIT], 1'b1);
      apb(1'b1, CTRL_OFF, 32'h5);
      check("flag", flag, 1'b0);
      check("oe", oe, 1'b0);
      pulse(1'b1, 7'h40);
      apb(1'b1, CTRL_OFF, 32'h3);
      check("flag", flag, 1'b0);
      pulse(1'b1, 7'h40);
      apb(1'b1, CTRL_OFF, 32'h0);
      check("flag", flag, 1'b0);
      // second reset in mid-run with the flag set
      apb(1'b1, CTRL_OFF, 32'h1);
      pulse(1'b1, 7'h40);
      check("flag", flag, 1'b1);
      presetn <= 1'b0;
      @(negedge pclk);
      check("flag", flag, 1'b0);
      check("oe", oe, 1'b0);
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      results();
   end
endmodule
